// ==== tsec_consts.svh ====
/*
 * Offsets, field positions, reset values and fixed levels of the two-stage
 * event controller. Definitions only; included by tsec_pkg, tsec_router and tsec_ctrl.
 */
`ifndef TSEC_CONSTS_SVH
`define TSEC_CONSTS_SVH

// register byte offsets on the wishbone port
`define TSEC_OFS_CORE_MASK   8'h00
`define TSEC_OFS_LATCH       8'h04
`define TSEC_OFS_PEND        8'h08
`define TSEC_OFS_CTRL        8'h0C
`define TSEC_OFS_RAISE       8'h10
`define TSEC_OFS_EXC_CAUSE   8'h14
`define TSEC_OFS_RT_MASK     8'h20
`define TSEC_OFS_RT_STATUS   8'h24
`define TSEC_OFS_ASSIGN0     8'h30
`define TSEC_OFS_ASSIGN1     8'h34
`define TSEC_OFS_ASSIGN2     8'h38
`define TSEC_OFS_ASSIGN3     8'h3C
// return address window: 16 words from here, one per level
`define TSEC_OFS_RET_BASE    2'b01

// router register indices
`define TSEC_RIDX_MASK       3'h0
`define TSEC_RIDX_ASSIGN0    3'h1
`define TSEC_RIDX_ASSIGN3    3'h4

// fixed event levels
`define TSEC_LVL_EMU         4'h0
`define TSEC_LVL_RST         4'h1
`define TSEC_LVL_NMI         4'h2
`define TSEC_LVL_EXC         4'h3
`define TSEC_LVL_RSVD        4'h4
`define TSEC_LVL_HWERR       4'h5
`define TSEC_LVL_TMR         4'h6
`define TSEC_LVL_GP_FIRST    4'h7
`define TSEC_LVL_NONE        5'h10

// field positions
`define TSEC_CTRL_GP_EN_BIT  0
`define TSEC_CAUSE_MIS_BIT   0
`define TSEC_CAUSE_UND_BIT   1

// reset values
`define TSEC_CORE_MASK_RST   16'h0000
`define TSEC_NONMASKABLE     16'h000F
`define TSEC_NONMASKABLE_LOW 4'hF
`define TSEC_CTRL_RST        1'b1
`define TSEC_RT_MASK_RST     32'h00000000
// default source assignment, one nibble per id holding level minus seven
`define TSEC_ASSIGN0_RST     32'h22211000
`define TSEC_ASSIGN1_RST     32'h43333332
`define TSEC_ASSIGN2_RST     32'h55555444
`define TSEC_ASSIGN3_RST     32'h66655555
// ids that carry a second, shared source
`define TSEC_SHARED_IDS      32'h80060006

`endif

// ==== tsec_pkg.sv ====
/*
 * Types and shared helper functions of the two-stage event controller.
 * Assumes tsec_consts.svh on the include path.
 */
`include "tsec_consts.svh"

package tsec_pkg;

    typedef logic [3:0]  tsec_level_type;
    typedef logic [15:0] tsec_evvec_type;
    typedef logic [4:0]  tsec_rank_type;

    // lowest set bit, or the none value when nothing is set
    function automatic tsec_rank_type tsec_lowest(input tsec_evvec_type v);
        tsec_rank_type r;
        r = `TSEC_LVL_NONE;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : tsec_lowest

    // byte-lane merge of a wishbone write
    function automatic logic [31:0] tsec_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : tsec_merge

endpackage : tsec_pkg

// ==== tsec_router.sv ====
/*
 * System-level router: combines shared sources, masks, maps each peripheral
 * id onto one of nine general-purpose levels and registers the result.
 * Assumes register writes come as single-cycle strobes from tsec_ctrl.
 */
`timescale 1ns/1ps
`include "tsec_consts.svh"

module tsec_router
    import tsec_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // peripheral sources
    input  wire logic [31:0] periph_req,
    input  wire logic [31:0] periph_req_alt,
    // register writes
    input  wire logic        reg_we,
    input  wire logic [2:0]  reg_idx,
    input  wire logic [31:0] reg_wdata,
    input  wire logic [3:0]  reg_wsel,
    // register state
    output logic [31:0]      router_mask_q,
    output logic [31:0]      router_status_q,
    output logic [3:0][31:0] assign_q,
    // levels 7..15 towards the prioritizer
    output logic [8:0]       gp_lines_q
);

    logic [31:0] combined;
    logic [8:0]  gp_lines_d;

    assign combined = periph_req | (periph_req_alt & `TSEC_SHARED_IDS);

    always_comb begin
        logic [3:0] nib;
        nib        = 4'h0;
        gp_lines_d = 9'h000;
        for (int id = 0; id < 32; id++) begin
            nib = assign_q[id / 8][(id % 8) * 4 +: 4];
            if (combined[id] && router_mask_q[id] && nib < 4'h9) begin
                gp_lines_d[nib] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gp_lines_q      <= 9'h000;
            router_status_q <= 32'h00000000;
        end else begin
            gp_lines_q      <= gp_lines_d;
            router_status_q <= combined;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            router_mask_q <= `TSEC_RT_MASK_RST;
            assign_q[0]   <= `TSEC_ASSIGN0_RST;
            assign_q[1]   <= `TSEC_ASSIGN1_RST;
            assign_q[2]   <= `TSEC_ASSIGN2_RST;
            assign_q[3]   <= `TSEC_ASSIGN3_RST;
        end else if (reg_we) begin
            if (reg_idx == `TSEC_RIDX_MASK) begin
                router_mask_q <= tsec_merge(router_mask_q, reg_wdata, reg_wsel);
            end else if (reg_idx <= `TSEC_RIDX_ASSIGN3) begin
                assign_q[2'(reg_idx - 3'h1)] <= tsec_merge(assign_q[2'(reg_idx - 3'h1)],
                                                           reg_wdata, reg_wsel);
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_mask_blocks: assert property (router_mask_q == 32'h0 |=> gp_lines_q == 9'h000)
        else $error("masked router still drives a level");
    a_shared_or: assert property (periph_req_alt[31] |=> router_status_q[31])
        else $error("shared source not seen in status");

endmodule : tsec_router

// ==== tsec_ctrl.sv ====
/*
 * Two-stage event controller top: wishbone slave, router instance, edge
 * latches, fixed-priority nesting prioritizer and return address store.
 * Assumes the pipeline accepts a vector whenever core_ready is high and
 * issues core_ret when a handler of the given level returns.
 */
// Contract
// - five event classes, emulation, reset, nmi, exception, interrupt, handled separately.
// - emulation event puts the core into emulation mode under test port control.
// - nmi comes from the watchdog request or the external nmi pin.
// - exceptions are taken before the faulting instruction completes.
// - nested handlers allowed; higher priority pending always served first.
// - each class keeps its own return address; state saved on entry.
// - peripheral requests go through the router onto general-purpose levels.
// - nine general-purpose levels, seven through fifteen.
// - fixed priorities emulation 0, reset 1, nmi 2, exception 3, 4 unused.
// - hardware error 5, core timer 6, general levels 7 to 15.
// - router has a default mapping after reset; software may rewrite it.
// - ids 0, 1, 2 map to level 7 by default.
// - ids 3, 4 to level 8; ids 5 to 8 to level 9.
// - ids 9 to 14 map to level 10 by default.
// - ids 15 to 18 map to level 11 by default.
// - ids 19 to 28 map to level 12 by default.
// - ids 29 to 31 map to level 13 by default.
// - router mask bit set passes a source, clear blocks it.
// - router status bit shows the live request of each id.
// - latch sets two cycles after rising edge, clears when pending sets.
// - at least three cycles from rising edge to pending.
`timescale 1ns/1ps
`include "tsec_consts.svh"

module tsec_ctrl
    import tsec_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // peripheral sources
    input  wire logic [31:0] periph_req,
    input  wire logic [31:0] periph_req_alt,
    // dedicated events
    input  wire logic        emu_req,
    input  wire logic        rst_req,
    input  wire logic        nmi_pin_req,
    input  wire logic        wdog_nmi_req,
    input  wire logic        exc_req,
    input  wire logic        exc_misalign,
    input  wire logic        exc_undef,
    input  wire logic        hw_err_req,
    input  wire logic        core_timer_req,
    // pipeline side
    input  wire logic        core_ready,
    input  wire logic [31:0] core_pc,
    input  wire logic        core_ret,
    input  wire logic [3:0]  core_ret_level,
    output logic             vec_valid_q,
    output tsec_level_type   vec_level_q,
    output logic             state_save_q,
    output logic             ret_valid_q,
    output logic [31:0]      ret_pc_q,
    output logic             emu_mode_q,
    output logic             sys_rst_q,
    output logic             exc_kill_q,
    output tsec_evvec_type   pend_q
);

    // bus decode
    logic            bus_req;
    logic            bus_wr;
    logic [7:0]      bus_ofs;
    logic [31:0]     rd_data;

    // router side
    logic            rt_we;
    logic [2:0]      rt_idx;
    logic [31:0]     rt_mask;
    logic [31:0]     rt_status;
    logic [3:0][31:0] rt_assign;
    logic [8:0]      gp_lines;

    // prioritizer state
    tsec_evvec_type  core_mask_q;
    logic            gp_en_q;
    tsec_evvec_type  latch_q;
    tsec_evvec_type  latch_d;
    tsec_evvec_type  ev_prev_q;
    tsec_evvec_type  ev_in;
    tsec_evvec_type  ev_edge;
    tsec_evvec_type  raise;
    tsec_evvec_type  eff_mask;
    tsec_evvec_type  eligible;
    tsec_evvec_type  take_vec;
    tsec_evvec_type  ret_vec;
    tsec_evvec_type  pend_d;
    tsec_rank_type   cand;
    tsec_rank_type   cur_lvl;
    logic            issue;
    logic            ret_ok;
    logic [1:0]      exc_cause_q;
    logic [31:0]     ret_addr [16];
    logic [31:0]     ret_sel_addr;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land at the edge where the master sees ack
    assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign bus_ofs = {wb_adr_i[7:2], 2'b00};

    // router registers sit at 0x20 and 0x30..0x3C
    always_comb begin
        rt_we  = 1'b0;
        rt_idx = `TSEC_RIDX_MASK;
        case (bus_ofs)
            `TSEC_OFS_RT_MASK: begin
                rt_we  = bus_wr;
                rt_idx = `TSEC_RIDX_MASK;
            end
            `TSEC_OFS_ASSIGN0, `TSEC_OFS_ASSIGN1, `TSEC_OFS_ASSIGN2, `TSEC_OFS_ASSIGN3: begin
                rt_we  = bus_wr;
                rt_idx = 3'(bus_ofs[3:2]) + `TSEC_RIDX_ASSIGN0;
            end
            default: begin
                rt_we  = 1'b0;
                rt_idx = `TSEC_RIDX_MASK;
            end
        endcase
    end

    tsec_router u_router (
        .sys_clk         (sys_clk),
        .resetn          (resetn),
        .periph_req      (periph_req),
        .periph_req_alt  (periph_req_alt),
        .reg_we          (rt_we),
        .reg_idx         (rt_idx),
        .reg_wdata       (wb_dat_i),
        .reg_wsel        (wb_sel_i),
        .router_mask_q   (rt_mask),
        .router_status_q (rt_status),
        .assign_q        (rt_assign),
        .gp_lines_q      (gp_lines)
    );

    // read mux; unmapped offsets read zero
    assign ret_sel_addr = ret_addr[core_ret_level];

    always_comb begin
        rd_data = 32'h00000000;
        if (wb_adr_i[7:6] == `TSEC_OFS_RET_BASE) begin
            rd_data = ret_addr[wb_adr_i[5:2]];
        end else begin
            case (bus_ofs)
                `TSEC_OFS_CORE_MASK: rd_data = {16'h0000, core_mask_q & ~eff_unused()};
                `TSEC_OFS_LATCH:     rd_data = {16'h0000, latch_q};
                `TSEC_OFS_PEND:      rd_data = {16'h0000, pend_q};
                `TSEC_OFS_CTRL:      rd_data = {31'h00000000, gp_en_q};
                `TSEC_OFS_EXC_CAUSE: rd_data = {30'h00000000, exc_cause_q};
                `TSEC_OFS_RT_MASK:   rd_data = rt_mask;
                `TSEC_OFS_RT_STATUS: rd_data = rt_status;
                `TSEC_OFS_ASSIGN0:   rd_data = rt_assign[0];
                `TSEC_OFS_ASSIGN1:   rd_data = rt_assign[1];
                `TSEC_OFS_ASSIGN2:   rd_data = rt_assign[2];
                `TSEC_OFS_ASSIGN3:   rd_data = rt_assign[3];
                default:             rd_data = 32'h00000000;
            endcase
        end
    end

    // bits that can never be masked or never exist
    function automatic tsec_evvec_type eff_unused();
        return `TSEC_NONMASKABLE | (16'h0001 << `TSEC_LVL_RSVD);
    endfunction : eff_unused

    // one wait-free answer: ack in the cycle after the request is seen
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            core_mask_q <= `TSEC_CORE_MASK_RST;
            gp_en_q     <= `TSEC_CTRL_RST;
        end else if (bus_wr) begin
            if (bus_ofs == `TSEC_OFS_CORE_MASK) begin
                core_mask_q <= 16'(tsec_merge({16'h0000, core_mask_q}, wb_dat_i, wb_sel_i));
            end
            if (bus_ofs == `TSEC_OFS_CTRL && wb_sel_i[0]) begin
                gp_en_q <= wb_dat_i[`TSEC_CTRL_GP_EN_BIT];
            end
        end
    end

    // software-raised events, one way to reach levels 14 and 15 besides router nibbles 7 and 8
    assign raise = (bus_wr && bus_ofs == `TSEC_OFS_RAISE) ?
                   16'(tsec_merge(32'h0, wb_dat_i, wb_sel_i)) : 16'h0000;

    // each class on its own level
    assign ev_in = {gp_lines, core_timer_req, hw_err_req, 1'b0, exc_req,
                    nmi_pin_req | wdog_nmi_req, rst_req, emu_req};

    assign ev_edge = ev_in & ~ev_prev_q;

    assign eff_mask = {core_mask_q[15:7] & {9{gp_en_q}}, core_mask_q[6:5], 1'b0,
                       `TSEC_NONMASKABLE_LOW};
    assign eligible = latch_q & eff_mask;
    assign cand     = tsec_lowest(eligible);
    assign cur_lvl  = tsec_lowest(pend_q);

    // only a more urgent event preempts
    assign issue    = core_ready && (cand < cur_lvl);
    assign take_vec = issue ? (16'h0001 << cand[3:0]) : 16'h0000;

    assign ret_ok   = core_ret && pend_q[core_ret_level];
    assign ret_vec  = ret_ok ? (16'h0001 << core_ret_level) : 16'h0000;

    // set wins over clear; level four never latches
    always_comb begin
        latch_d = (latch_q & ~take_vec) | ev_edge | raise;
        latch_d[`TSEC_LVL_RSVD] = 1'b0;
        pend_d  = (pend_q & ~ret_vec) | take_vec;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ev_prev_q <= 16'h0000;
            latch_q   <= 16'h0000;
            pend_q    <= 16'h0000;
        end else begin
            ev_prev_q <= ev_in;
            latch_q   <= latch_d;
            // pending one edge after the latch
            pend_q    <= pend_d;
        end
    end

    // vector handoff and state save
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            vec_valid_q  <= 1'b0;
            vec_level_q  <= 4'h0;
            state_save_q <= 1'b0;
            sys_rst_q    <= 1'b0;
        end else begin
            vec_valid_q  <= issue;
            state_save_q <= issue;
            sys_rst_q    <= issue && cand[3:0] == `TSEC_LVL_RST;
            if (issue) begin
                vec_level_q <= cand[3:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (issue) begin
            ret_addr[cand[3:0]] <= core_pc;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ret_valid_q <= 1'b0;
            ret_pc_q    <= 32'h00000000;
        end else begin
            ret_valid_q <= ret_ok;
            if (ret_ok) begin
                ret_pc_q <= ret_sel_addr;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            emu_mode_q <= 1'b0;
        end else if (issue && cand[3:0] == `TSEC_LVL_EMU) begin
            emu_mode_q <= 1'b1;
        end else if (ret_vec[`TSEC_LVL_EMU]) begin
            emu_mode_q <= 1'b0;
        end
    end

    // kill the faulting instruction at once, cause kept for software
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            exc_kill_q  <= 1'b0;
            exc_cause_q <= 2'b00;
        end else begin
            exc_kill_q <= ev_edge[`TSEC_LVL_EXC];
            if (ev_edge[`TSEC_LVL_EXC]) begin
                exc_cause_q[`TSEC_CAUSE_MIS_BIT] <= exc_misalign;
                exc_cause_q[`TSEC_CAUSE_UND_BIT] <= exc_undef;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // past values the checks compare against
    tsec_rank_type cur_lvl_prev;
    tsec_evvec_type eff_mask_prev;
    always_ff @(posedge sys_clk) begin
        cur_lvl_prev  <= cur_lvl;
        eff_mask_prev <= eff_mask;
    end

    a_edge_sets_latch: assert property (ev_edge[6] |=> latch_q[6] || pend_q[6])
        else $error("core timer edge not latched");
    a_nmi_two_sources: assert property (!ev_prev_q[2] && wdog_nmi_req |=>
                                        latch_q[2] || pend_q[2])
        else $error("watchdog nmi request lost");
    a_issue_nesting: assert property (vec_valid_q |-> vec_level_q < cur_lvl_prev)
        else $error("vector issued without outranking active level");
    a_issue_unmasked: assert property (vec_valid_q |-> eff_mask_prev[vec_level_q])
        else $error("masked event issued");
    a_take_clears_latch: assert property (
        issue && !ev_edge[cand[3:0]] && !raise[cand[3:0]]
        |=> vec_valid_q && pend_q[vec_level_q] && !latch_q[vec_level_q])
        else $error("latch not handed to pending");
    a_level4_unused: assert property (!latch_q[4] && !pend_q[4])
        else $error("reserved level became active");
    a_emu_mode_entry: assert property (vec_valid_q && vec_level_q == 4'h0 |-> emu_mode_q)
        else $error("emulation vector without emulation mode");
    a_ret_address: assert property (ret_ok |=> ret_valid_q ##0 ret_pc_q == $past(ret_sel_addr))
        else $error("return address mismatch");
    a_exc_kill: assert property (ev_edge[3] |=> exc_kill_q ##1 !exc_kill_q || ev_edge[3])
        else $error("exception did not kill instruction");
    a_gp_min_latency: assert property (ev_edge[7] && !pend_q[7] |=> !pend_q[7])
        else $error("level seven pending too early");
    a_wb_single_ack: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    c_nested_entry: cover property (vec_valid_q && $countones(pend_q) > 1);
    c_emu_entry:    cover property (vec_valid_q && vec_level_q == 4'h0);
    c_gp_entry:     cover property (vec_valid_q && vec_level_q >= 4'h7);
    c_return:       cover property (ret_valid_q);

endmodule : tsec_ctrl

// ==== tsec_core_model.sv ====
/*
 * Pipeline-side model of the two-stage event controller: accepts vectors,
 * keeps a stack of entered levels and returns them on request.
 * Assumes the bench drives stall and ret_go right after rising edges.
 */
`timescale 1ns/1ps

module tsec_core_model (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // bench control
    input  wire logic        stall,
    input  wire logic        ret_go,
    // controller side
    input  wire logic        vec_valid_q,
    input  wire logic [3:0]  vec_level_q,
    output logic             core_ready,
    output logic             core_ret,
    output logic [3:0]       core_ret_level,
    output logic [31:0]      core_pc
);
    logic [3:0] stack_q[$];

    // stall models a busy pipeline, so vectors can pile up
    assign core_ready = !stall;

    // returns innermost level first, nesting kept
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            core_ret <= 1'b0;
            core_ret_level <= 4'h0;
            core_pc <= 32'h00001000;
            stack_q.delete();
        end else begin
            core_pc <= core_pc + 32'h4;
            core_ret <= 1'b0;
            if (vec_valid_q) begin
                stack_q.push_back(vec_level_q);
            end
            if (ret_go && stack_q.size() > 0) begin
                core_ret <= 1'b1;
                core_ret_level <= stack_q.pop_back();
            end
        end
    end
endmodule : tsec_core_model

// ==== tb_two_stage_event_controller.sv ====
/*
 * Self-checking bench of the two-stage event controller top.
 * Assumes tsec_pkg compiled first and tsec_core_model as pipeline.
 */
`timescale 1ns/1ps

module tb_two_stage_event_controller;
    import tsec_pkg::*;
    logic sys_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stall, ret_go;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, core_ret_level;
    logic [31:0] wb_dat_i, wb_dat_o, periph_req, periph_req_alt, core_pc, ret_pc_q, rd, pc_exp;
    logic [6:0] ev;
    logic exc_misalign, exc_undef, core_ready, core_ret, vec_valid_q, state_save_q;
    logic ret_valid_q, emu_mode_q, sys_rst_q, exc_kill_q;
    tsec_level_type vec_level_q;
    tsec_evvec_type pend_q;
    int err_count, tests_run, n;
    // event level per dedicated input: emu rst nmi_pin wdog exc hw_err timer
    logic [27:0] lv_tab = 28'h6532210;

    tsec_ctrl dut (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .periph_req(periph_req), .periph_req_alt(periph_req_alt), .emu_req(ev[0]),
        .rst_req(ev[1]), .nmi_pin_req(ev[2]), .wdog_nmi_req(ev[3]), .exc_req(ev[4]),
        .exc_misalign(exc_misalign), .exc_undef(exc_undef), .hw_err_req(ev[5]),
        .core_timer_req(ev[6]), .core_ready(core_ready), .core_pc(core_pc),
        .core_ret(core_ret), .core_ret_level(core_ret_level), .vec_valid_q(vec_valid_q),
        .vec_level_q(vec_level_q), .state_save_q(state_save_q), .ret_valid_q(ret_valid_q),
        .ret_pc_q(ret_pc_q), .emu_mode_q(emu_mode_q), .sys_rst_q(sys_rst_q),
        .exc_kill_q(exc_kill_q), .pend_q(pend_q));
    tsec_core_model pipe (.sys_clk(sys_clk), .resetn(resetn), .stall(stall), .ret_go(ret_go),
        .vec_valid_q(vec_valid_q), .vec_level_q(vec_level_q), .core_ready(core_ready),
        .core_ret(core_ret), .core_ret_level(core_ret_level), .core_pc(core_pc));

    always #5 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // classic single cycle; waits for ack with no limit, expects it on the second edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hF};
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        chk(32'(k), 32'h2);
    endtask : wb

    task automatic wait_hi(input bit r);
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while ((r ? ret_valid_q : vec_valid_q) !== 1'b1 && k < 40);
        chk(32'(k >= 40), 32'h0);
    endtask : wait_hi

    task automatic retn();
        @(posedge sys_clk);
        ret_go <= 1'b1;
        @(posedge sys_clk);
        ret_go <= 1'b0;
        wait_hi(1'b1);
    endtask : retn

    // default router map, nibble = level minus seven
    function automatic logic [31:0] dflt(input int k);
        logic [31:0] w;
        int id;
        for (int j = 0; j < 8; j++) begin
            id = 8 * k + j;
            w[4*j +: 4] = id < 3 ? 4'h0 : id < 5 ? 4'h1 : id < 9 ? 4'h2 : id < 15 ? 4'h3 :
                          id < 19 ? 4'h4 : id < 29 ? 4'h5 : 4'h6;
        end
        return w;
    endfunction : dflt

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // stuck design must not hang the run
    initial begin
        #200000;
        err_count++;
        close_out();
    end

    initial begin
        {sys_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, stall, ret_go} = 7'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i, periph_req, periph_req_alt, ev} = '0;
        {exc_misalign, exc_undef} = 2'b00;
        err_count = 0;
        tests_run = 0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        for (int k = 0; k < 4; k++) begin
            wb(1'b0, 8'h30 + 8'(4 * k), 32'h0);
            chk(rd, dflt(k));
        end
        wb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 8'h00, 32'h0000FFE0);
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        @(posedge sys_clk);
        periph_req[3] <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (pend_q[8] !== 1'b1 && n < 20);
        chk(n, 3);
        chk(vec_level_q, 8);
        wb(1'b0, 8'h24, 32'h0);
        chk(rd[3], 1);
        periph_req[3] <= 1'b0;
        retn();
        chk(pend_q, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            ev[i] <= 1'b1;
            exc_misalign <= (i == 4);
            repeat (2) @(posedge sys_clk);
            chk(exc_kill_q, 32'(i == 4));
            wait_hi(1'b0);
            pc_exp = core_pc - 32'h4;
            chk(vec_level_q, lv_tab[4*i +: 4]);
            chk(state_save_q, 1);
            chk(emu_mode_q, 32'(i == 0));
            chk(sys_rst_q, 32'(i == 1));
            if (i == 4) wb(1'b0, 8'h14, 32'h0);
            if (i == 4) chk(rd[1:0], 1);
            ev[i] <= 1'b0;
            retn();
            chk(ret_pc_q, pc_exp);
        end
        stall <= 1'b1;
        ev[6] <= 1'b1;
        periph_req[19] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        stall <= 1'b0;
        wait_hi(1'b0);
        chk(vec_level_q, 6);
        repeat (6) @(posedge sys_clk);
        chk(pend_q[12], 0);
        ev[6] <= 1'b0;
        retn();
        wait_hi(1'b0);
        chk(vec_level_q, 12);
        periph_req[0] <= 1'b1;
        wait_hi(1'b0);
        chk(pend_q, 16'h1080);
        periph_req[0] <= 1'b0;
        periph_req[19] <= 1'b0;
        retn();
        retn();
        periph_req_alt[31] <= 1'b1;
        wait_hi(1'b0);
        chk(vec_level_q, 13);
        periph_req_alt[31] <= 1'b0;
        retn();
        wb(1'b1, 8'h20, 32'hFFFFFDFF);
        periph_req[9] <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk(pend_q, 16'h0000);
        periph_req[9] <= 1'b0;
        wb(1'b1, 8'h30, (dflt(0) & 32'hFFFF0FFF) | 32'h00004000);
        periph_req[3] <= 1'b1;
        wait_hi(1'b0);
        chk(vec_level_q, 11);
        periph_req[3] <= 1'b0;
        retn();
        wb(1'b1, 8'h0C, 32'h0);
        wb(1'b1, 8'h10, 32'h00004000);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h00004000);
        wb(1'b1, 8'h0C, 32'h1);
        wait_hi(1'b0);
        chk(vec_level_q, 14);
        retn();
        close_out();
    end
endmodule : tb_two_stage_event_controller
